// File: hdl/asc_pkg.sv
/*
  Package for the converter scan control and DMA channel block: register
  offsets, field positions, reset values and the sequencer state type.
  Assumes an APB slave with 32-bit data, one aligned word per register.
*/
package asc_pkg;
  // Register byte offsets
  localparam logic [7:0] TRIG_CFG_OFS = 8'h00;
  localparam logic [7:0] REF_CFG_OFS  = 8'h04;
  localparam logic [7:0] UPPER_OFS    = 8'h08;
  localparam logic [7:0] LOWER_OFS    = 8'h0C;
  localparam logic [7:0] CHSEL_OFS    = 8'h10;
  localparam logic [7:0] DMA_CTL_OFS  = 8'h14;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1C;
  localparam logic [7:0] MODE_OFS     = 8'h20;
  localparam logic [7:0] DMA_CNT_OFS  = 8'h24;
  localparam logic [7:0] DMA_PTR_OFS  = 8'h28;
  // Field positions
  localparam int TRIG_SEL_LO   = 0;
  localparam int ONESHOT_BIT   = 5;
  localparam int TMODE_LO      = 6;
  localparam int RES_BIT       = 0;
  localparam int LOW_POWER_WAKE_STATE_BIT    = 2;
  localparam int RCHK_BIT      = 3;
  localparam int NEGREF_BIT    = 5;
  localparam int POSREF_LO     = 6;
  localparam int ISS_BIT       = 7;
  localparam int DMA_EN_BIT    = 7;
  localparam int DMA_ACT_BIT   = 0;
  localparam int DMA_IRQ_BIT   = 6;
  localparam int SCAN_MODE_BIT = 6;
  localparam int CONV_GO_BIT   = 7;
  // Field encodings
  localparam logic [1:0] TRIG_NONE   = 2'h0;
  localparam logic [1:0] TRIG_TIMER  = 2'h1;
  localparam logic [1:0] TRIG_RTC    = 2'h2;
  localparam logic [1:0] TRIG_ITV    = 2'h3;
  localparam logic [1:0] TMODE_NOWAIT = 2'h2;
  localparam logic [1:0] TMODE_WAIT   = 2'h3;
  localparam logic [1:0] POSREF_BAD   = 2'h3;
  localparam logic [2:0] LAST_CH      = 3'h3;
  // Reset values
  localparam logic [7:0] TRIG_CFG_RST = 8'h00;
  localparam logic [7:0] REF_CFG_RST  = 8'h00;
  localparam logic [7:0] UPPER_RST    = 8'hFF;
  localparam logic [7:0] LOWER_RST    = 8'h00;
  localparam logic [7:0] CHSEL_RST    = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'hFF;
  localparam logic [7:0] CNT_RST      = 8'h00;
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_WAIT = 2'b01,
    ASC_CONV = 2'b10
  } asc_state_t;
endpackage

// File: hdl/asc_top.sv
/*
  Converter scan sequencing control with one DMA channel moving results to RAM.
  Assumes an APB master on pclk, an analog core answering conv_start with
  conv_done and a 10-bit result, trigger events as pulses from other clocks,
  and a RAM write port that accepts one word per cycle.
*/
`timescale 1ns/10ps
// Operation
// - Trigger select picks none, timer, RTC, interval
// - Bit 5 chooses sequential or one-shot
// - Trigger mode: software, hardware no-wait, hardware wait
// - Resolution bit gives 10-bit or 8-bit results
// - Bit 2 enables low_power_wake_state wake-up conversion
// - Range check sets inside or outside window
// - Reference selects drive references; 11 prohibited
// - Upper and lower limits gate conversion-end event
// - Scan starts at selected channel through 3
// - DMA enable bit 7 gates the channel
// - Active bit reads 1 until transfer completes
// - Done flag bit 6 sets at transfer end
// - Mode bit picks single select or scan
module asc_top (
  // APB
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Trigger events
  input  wire logic              timer_ch1_event,
  input  wire logic              rtc_event,
  input  wire logic              interval_timer_event,
  input  wire logic              low_power_wake_state,
  // Analog core
  output logic                   conv_start,
  output logic [2:0]             conv_channel,
  output logic                   resolution_select,
  output logic [1:0]             pos_reference_select,
  output logic                   neg_reference_select,
  output logic                   internal_source_select,
  output logic                   low_power_wake_state_wake_enable,
  output logic                   converter_powered,
  input  wire logic              conv_done,
  input  wire logic [9:0]        conv_result,
  // RAM write port
  output logic                   ram_we,
  output logic [7:0]             ram_addr,
  output logic [15:0]            ram_wdata,
  output logic                   dma_clk_en,
  // Interrupts
  output logic                   conversion_end_irq,
  output logic                   irq
);
  import asc_pkg::*;

  typedef struct packed {
    logic [7:0]  trig_cfg;
    logic [7:0]  ref_cfg;
    logic [7:0]  upper;
    logic [7:0]  lower;
    logic [7:0]  chsel;
    logic        dma_en;
    logic        dma_act;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic        scan_mode;
    logic        go;
    logic [7:0]  cnt;
    logic [7:0]  ptr;
    asc_state_t  st;
    logic [2:0]  ch;
    logic        start;
    logic        cend;
    logic        we;
    logic [7:0]  waddr;
    logic [15:0] wdata;
    logic [31:0] rdata;
    logic [2:0]  tsync0;
    logic [2:0]  tsync1;
    logic [2:0]  tprev;
    logic        wsync0;
    logic        wsync1;
  } asc_regs_t;

  asc_regs_t q;
  asc_regs_t d;

  // Decodes an APB address to a mapped-register hit
  function automatic logic asc_mapped(input logic [7:0] a);
    return a == TRIG_CFG_OFS || a == REF_CFG_OFS || a == UPPER_OFS ||
           a == LOWER_OFS || a == CHSEL_OFS || a == DMA_CTL_OFS ||
           a == IRQ_FLAG_OFS || a == IRQ_MASK_OFS || a == MODE_OFS ||
           a == DMA_CNT_OFS || a == DMA_PTR_OFS;
  endfunction

  logic        wr;
  logic        rd;
  logic [2:0]  trig_rise;
  logic        hw_trig;
  logic        sw_mode;
  logic        start_req;
  logic [9:0]  res_adj;
  logic [7:0]  cmp_val;
  logic        in_win;
  logic        cend_ok;
  logic        last_ch;
  logic        xfer;
  logic        xfer_last;
  logic [1:0]  tsel;

  always_comb begin
    d = q;
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    trig_rise = q.tsync1 & ~q.tprev;
    tsel = q.trig_cfg[TRIG_SEL_LO +: 2];
    case (tsel)
      TRIG_TIMER: hw_trig = trig_rise[0];
      TRIG_RTC:   hw_trig = trig_rise[1];
      TRIG_ITV:   hw_trig = trig_rise[2];
      default:    hw_trig = 1'b0;
    endcase
    // Low_power_wake_state wake lets hardware triggers run in the low-power state
    if (q.wsync1 && !q.ref_cfg[LOW_POWER_WAKE_STATE_BIT])
      hw_trig = 1'b0;
    sw_mode = !q.trig_cfg[TMODE_LO + 1];
    start_req = q.go && (sw_mode || hw_trig);
    res_adj = q.ref_cfg[RES_BIT] ? {2'h0, conv_result[9:2]} : conv_result;
    cmp_val = conv_result[9:2];
    in_win = (q.lower <= cmp_val) && (cmp_val <= q.upper);
    cend_ok = q.ref_cfg[RCHK_BIT] ? !in_win : in_win;
    last_ch = !q.scan_mode || q.ch == LAST_CH;
    xfer = conv_done && cend_ok && q.dma_en && q.dma_act;
    xfer_last = xfer && q.cnt == 8'h01;
    d.tsync0 = {interval_timer_event, rtc_event, timer_ch1_event};
    d.tsync1 = q.tsync0;
    d.tprev = q.tsync1;
    d.wsync0 = low_power_wake_state;
    d.wsync1 = q.wsync0;
    d.start = 1'b0;
    d.cend = 1'b0;
    d.we = 1'b0;
    // Conversion sequencer
    case (q.st)
      ASC_IDLE: begin
        if (start_req) begin
          d.st = ASC_CONV;
          d.ch = q.chsel[2:0];
          d.start = 1'b1;
        end
      end
      ASC_WAIT: begin
        if (!q.go)
          d.st = ASC_IDLE;
        else if (start_req) begin
          d.st = ASC_CONV;
          d.ch = q.chsel[2:0];
          d.start = 1'b1;
        end
      end
      ASC_CONV: begin
        if (conv_done) begin
          d.cend = cend_ok;
          if (!last_ch) begin
            d.ch = q.ch + 3'h1;
            d.start = 1'b1;
          end else if (q.trig_cfg[ONESHOT_BIT]) begin
            d.st = ASC_IDLE;
            d.go = 1'b0;
          end else if (sw_mode || q.trig_cfg[TMODE_LO +: 2] == TMODE_NOWAIT) begin
            d.ch = q.chsel[2:0];
            d.start = 1'b1;
          end else
            d.st = ASC_WAIT;
        end else if (!q.go)
          d.st = ASC_IDLE;
      end
      default: d.st = ASC_IDLE;
    endcase
    // DMA channel moves a result on each conversion end that passes the range check
    if (xfer) begin
      d.we = 1'b1;
      d.waddr = q.ptr;
      d.wdata = {6'h00, res_adj};
      d.ptr = q.ptr + 8'h01;
      d.cnt = q.cnt - 8'h01;
    end
    if (xfer_last)
      d.dma_act = 1'b0;
    // APB writes
    if (wr) begin
      case (paddr)
        TRIG_CFG_OFS: d.trig_cfg = pwdata[7:0] & 8'hE3;
        REF_CFG_OFS: begin
          d.ref_cfg = pwdata[7:0] & 8'hED;
          if (pwdata[POSREF_LO +: 2] == POSREF_BAD)
            d.ref_cfg[POSREF_LO +: 2] = q.ref_cfg[POSREF_LO +: 2];
        end
        UPPER_OFS: d.upper = pwdata[7:0];
        LOWER_OFS: d.lower = pwdata[7:0];
        CHSEL_OFS: if (pwdata[4:0] <= 5'(LAST_CH))
          d.chsel = pwdata[7:0] & 8'h9F;
        DMA_CTL_OFS: begin
          d.dma_en = pwdata[DMA_EN_BIT];
          if (pwdata[DMA_EN_BIT] && q.dma_en)
            d.dma_act = pwdata[DMA_ACT_BIT] && !xfer_last;
          else if (!pwdata[DMA_EN_BIT])
            d.dma_act = 1'b0;
        end
        IRQ_FLAG_OFS: d.flags = q.flags & ~pwdata[7:0];
        IRQ_MASK_OFS: d.mask = pwdata[7:0];
        MODE_OFS: begin
          d.scan_mode = pwdata[SCAN_MODE_BIT];
          d.go = pwdata[CONV_GO_BIT];
        end
        DMA_CNT_OFS: if (!q.dma_act) d.cnt = pwdata[7:0];
        DMA_PTR_OFS: if (!q.dma_act) d.ptr = pwdata[7:0];
        default: ;
      endcase
    end
    // Hardware set wins over a software clear
    if (xfer_last)
      d.flags[DMA_IRQ_BIT] = 1'b1;
    // APB read data captured in setup phase
    if (rd) begin
      case (paddr)
        TRIG_CFG_OFS: d.rdata = {24'h0, q.trig_cfg};
        REF_CFG_OFS:  d.rdata = {24'h0, q.ref_cfg};
        UPPER_OFS:    d.rdata = {24'h0, q.upper};
        LOWER_OFS:    d.rdata = {24'h0, q.lower};
        CHSEL_OFS:    d.rdata = {24'h0, q.chsel};
        DMA_CTL_OFS:  d.rdata = {24'h0, q.dma_en, 6'h00, q.dma_act};
        IRQ_FLAG_OFS: d.rdata = {24'h0, q.flags};
        IRQ_MASK_OFS: d.rdata = {24'h0, q.mask};
        MODE_OFS:     d.rdata = {24'h0, q.go, q.scan_mode, 4'h0, q.st};
        DMA_CNT_OFS:  d.rdata = {24'h0, q.cnt};
        DMA_PTR_OFS:  d.rdata = {24'h0, q.ptr};
        default:      d.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.trig_cfg <= TRIG_CFG_RST;
      q.ref_cfg <= REF_CFG_RST;
      q.upper <= UPPER_RST;
      q.lower <= LOWER_RST;
      q.chsel <= CHSEL_RST;
      q.mask <= MASK_RST;
      q.cnt <= CNT_RST;
      q.st <= ASC_IDLE;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !asc_mapped(paddr);
  assign conv_start = q.start;
  assign conv_channel = q.ch;
  assign resolution_select = q.ref_cfg[RES_BIT];
  assign pos_reference_select = q.ref_cfg[POSREF_LO +: 2];
  assign neg_reference_select = q.ref_cfg[NEGREF_BIT];
  assign internal_source_select = q.chsel[ISS_BIT];
  assign low_power_wake_state_wake_enable = q.ref_cfg[LOW_POWER_WAKE_STATE_BIT];
  assign converter_powered = q.go;
  assign ram_we = q.we;
  assign ram_addr = q.waddr;
  assign ram_wdata = q.wdata;
  assign dma_clk_en = q.dma_en;
  assign conversion_end_irq = q.cend;
  assign irq = |(q.flags & ~q.mask);
endmodule // asc_top

// File: tb/asc_checker.sv
/*
  Checker for asc_top: register side effects, window gating, DMA stores.
  Assumes writes land at the APB access edge and the limits are shadowed here.
*/
`timescale 1ns/10ps
module asc_checker
  import asc_pkg::*;
(
  // Clock, reset, APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Analog side
  input wire logic        resolution_select,
  input wire logic [1:0]  pos_reference_select,
  input wire logic        neg_reference_select,
  input wire logic        internal_source_select,
  input wire logic        low_power_wake_state_wake_enable,
  input wire logic        conv_done,
  input wire logic [9:0]  conv_result,
  // DMA and events
  input wire logic        ram_we,
  input wire logic [15:0] ram_wdata,
  input wire logic        dma_clk_en,
  input wire logic        conversion_end_irq
);
  logic [7:0] up_q, lo_q, wd_q;
  logic       inv_q, wr, pass;
  assign wr = psel && penable && pwrite;
  assign pass = ((conv_result[9:2] >= lo_q) && (conv_result[9:2] <= up_q)) ^ inv_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q  <= UPPER_RST;
      lo_q  <= LOWER_RST;
      inv_q <= 1'b0;
      wd_q  <= 8'h00;
    end else begin
      wd_q <= pwdata[7:0];
      if (wr && paddr == UPPER_OFS) up_q <= pwdata[7:0];
      if (wr && paddr == LOWER_OFS) lo_q <= pwdata[7:0];
      if (wr && paddr == REF_CFG_OFS) inv_q <= pwdata[RCHK_BIT];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  window_hit_a: assert property (conv_done && pass |=> conversion_end_irq)
    else $error("window hit gave no event");
  window_miss_a: assert property (conv_done && !pass |=> !conversion_end_irq)
    else $error("window miss gave an event");
  store_data_a: assert property (ram_we |-> ram_wdata == ($past(resolution_select) ?
    16'($past(conv_result) >> 2) : 16'($past(conv_result)))) else $error("stored data wrong");
  store_gate_a: assert property (ram_we |-> dma_clk_en && $past(conv_done))
    else $error("store without enable or conversion end");
  dma_enable_a: assert property (wr && paddr == DMA_CTL_OFS |=> dma_clk_en == wd_q[7])
    else $error("channel enable not followed");
  ref_fields_a: assert property (wr && paddr == REF_CFG_OFS |=>
    resolution_select == wd_q[RES_BIT] && low_power_wake_state_wake_enable == wd_q[LOW_POWER_WAKE_STATE_BIT] &&
    neg_reference_select == wd_q[NEGREF_BIT]) else $error("reference fields not followed");
  posref_take_a: assert property (wr && paddr == REF_CFG_OFS && pwdata[7:6] != POSREF_BAD
    |=> pos_reference_select == wd_q[7:6]) else $error("positive reference not taken");
  posref_keep_a: assert property (wr && paddr == REF_CFG_OFS && pwdata[7:6] == POSREF_BAD
    |=> $stable(pos_reference_select)) else $error("prohibited reference code taken");
  chan_keep_a: assert property (wr && paddr == CHSEL_OFS && pwdata[4:0] > 5'h03
    |=> $stable(internal_source_select)) else $error("prohibited channel write taken");
endmodule // asc_checker
bind asc_top asc_checker asc_checker_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .resolution_select, .pos_reference_select, .neg_reference_select,
  .internal_source_select, .low_power_wake_state_wake_enable, .conv_done, .conv_result, .ram_we, .ram_wdata,
  .dma_clk_en, .conversion_end_irq);

// File: tb/asc_top_test.sv
/*
  Bench for asc_top: register table, window-gated DMA scan, interrupt, trigger sources.
  Assumes the package offsets and a zero-wait APB slave.
*/
`timescale 1ns/10ps
module asc_top_test;
  import asc_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a, d, r; logic e;} asc_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        conv_done = 1'b0, pready, pslverr, slv, conv_start, resolution_select;
  logic        lpw = 1'b0;
  logic        neg_reference_select, internal_source_select, low_power_wake_state_wake_enable;
  logic        converter_powered, ram_we, dma_clk_en, conversion_end_irq, irq;
  logic [7:0]  paddr = 8'h00, ram_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [9:0]  conv_result = 10'h000;
  logic [2:0]  ev = 3'h0, conv_channel, start_ch;
  logic [1:0]  pos_reference_select;
  logic [15:0] ram_wdata;
  logic [23:0] wrq[$];
  int          n_mismatch = 0, samples_checked = 0, n_start = 0, n_seen = 0;
  asc_row_t rows[13] = '{'{1'h0, UPPER_OFS, 8'h00, 8'hFF, 1'h0},
    '{1'h0, LOWER_OFS, 8'h00, 8'h00, 1'h0}, '{1'h0, IRQ_MASK_OFS, 8'h00, 8'hFF, 1'h0},
    '{1'h0, TRIG_CFG_OFS, 8'h00, 8'h00, 1'h0}, '{1'h0, REF_CFG_OFS, 8'h00, 8'h00, 1'h0},
    '{1'h0, CHSEL_OFS, 8'h00, 8'h00, 1'h0}, '{1'h1, TRIG_CFG_OFS, 8'hE3, 8'hE3, 1'h0},
    '{1'h1, REF_CFG_OFS, 8'hAD, 8'hAD, 1'h0}, '{1'h1, REF_CFG_OFS, 8'hED, 8'hAD, 1'h0},
    '{1'h1, CHSEL_OFS, 8'h83, 8'h83, 1'h0}, '{1'h1, CHSEL_OFS, 8'h04, 8'h83, 1'h0},
    '{1'h1, UPPER_OFS, 8'h5A, 8'h5A, 1'h0}, '{1'h1, 8'h3C, 8'h12, 8'h00, 1'h1}};
  logic [15:0] cfg[10] = '{{REF_CFG_OFS, 8'h00}, {UPPER_OFS, 8'hFF}, {LOWER_OFS, 8'h40},
    {CHSEL_OFS, 8'h01}, {DMA_CNT_OFS, 8'h02}, {DMA_PTR_OFS, 8'h10}, {DMA_CTL_OFS, 8'h80},
    {DMA_CTL_OFS, 8'h81}, {TRIG_CFG_OFS, 8'h20}, {MODE_OFS, 8'hC0}};
  asc_top asc_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_ch1_event(ev[0]), .rtc_event(ev[1]), .interval_timer_event(ev[2]),
    .low_power_wake_state(lpw), .conv_start, .conv_channel, .resolution_select,
    .pos_reference_select, .neg_reference_select, .internal_source_select, .low_power_wake_state_wake_enable,
    .converter_powered, .conv_done, .conv_result, .ram_we, .ram_addr, .ram_wdata, .dma_clk_en,
    .conversion_end_irq, .irq);
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    if (conv_start === 1'b1) begin
      n_start++;
      start_ch = conv_channel;
    end
    if (ram_we === 1'b1) wrq.push_back({ram_addr, ram_wdata});
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      slv = pslverr;
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end else begin
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic wstart();
    for (int i = 0; i < 40 && n_start == n_seen; i++) @(negedge pclk);
    if (n_start == n_seen) begin
      n_mismatch++;
      finish_test();
    end else n_seen++;
  endtask
  task automatic conv(input logic [2:0] ch, input logic [9:0] res, input logic ok);
    wstart();
    chk(start_ch, ch);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_result <= res;
    @(posedge pclk);
    conv_done <= 1'b0;
    @(negedge pclk);
    chk(conversion_end_irq, ok);
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge pclk);
    ev <= e;
    repeat (3) @(posedge pclk);
    ev <= 3'h0;
    repeat (8) @(negedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[j]) begin
      if (rows[j].wr) apb(1'b1, rows[j].a, {24'h0, rows[j].d});
      apb(1'b0, rows[j].a, 32'h0);
      chk(rd, {24'h0, rows[j].r});
      chk(slv, rows[j].e);
    end
    $display("register table done");
    foreach (cfg[j]) apb(1'b1, cfg[j][15:8], {24'h0, cfg[j][7:0]});
    conv(3'h1, 10'h200, 1'b1);
    conv(3'h2, 10'h0FF, 1'b0);
    conv(3'h3, 10'h3FC, 1'b1);
    repeat (6) @(negedge pclk);
    chk(n_start, n_seen);
    chk(wrq.size(), 2);
    chk(wrq[0], 24'h100200);
    chk(wrq[1], 24'h1103FC);
    apb(1'b0, DMA_CTL_OFS, 32'h0);
    chk(rd, 32'h80);
    apb(1'b0, MODE_OFS, 32'h0);
    chk(rd, 32'h40);
    apb(1'b0, IRQ_FLAG_OFS, 32'h0);
    chk(rd, 32'h40);
    $display("scan transfer done");
    @(negedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, IRQ_MASK_OFS, 32'hBF);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, IRQ_FLAG_OFS, 32'h40);
    @(negedge pclk);
    chk(irq, 1'b0);
    $display("interrupt done");
    for (int k = 1; k < 4; k++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, TRIG_CFG_OFS, 32'h80 | k);
      apb(1'b1, MODE_OFS, 32'h80);
      pulse(3'(1 << (k % 3)));
      chk(n_start, n_seen);
      pulse(3'(1 << (k - 1)));
      wstart();
    end
    $display("trigger sources done");
    @(posedge pclk);
    presetn <= 1'b0;
    lpw <= 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, TRIG_CFG_OFS, 32'hC1);
    apb(1'b1, MODE_OFS, 32'h80);
    pulse(3'h1);
    chk(n_start, n_seen);
    apb(1'b1, REF_CFG_OFS, 32'h04);
    pulse(3'h1);
    conv(3'h0, 10'h200, 1'b1);
    repeat (8) @(negedge pclk);
    chk(n_start, n_seen);
    pulse(3'h1);
    wstart();
    $display("low_power_wake_state and wait mode done");
    finish_test();
  end
endmodule // asc_top_test
